// >>> hdl/pmw_power_wake.sv
/*
  Power mode and wake-up control: wake configuration, touch flag,
  unit mode and power control registers, mode entry and wake logic.
  Assumes the core drives one-cycle SFR strobes on clk_sys and that the
  clock gate outside honours clk_gate_en; event pins are asynchronous.
*/
// How it works
// - Sleep bit written one enters sleep
// - Suspend bit written one enters suspend
// - Clear bit wipes all wake flags
// - Reset pin glitch sets read-only flag
// - RTC fail/alarm bits: enable written, flag read
// - Port match enable written, flag read
// - Comparator rise enable written, flag read
// - Flags update always, enabled or not
// - No sleep or suspend entry while any flag set
// - Flags read zero two clocks after suspend
// - Touch flag bit zero, upper bits zero
// - Mode bit seven routes RTC output
// - Mode bit six enables wake request pin
// - Leaving sleep drives wake request low
// - Bit five disables monitor, low bits zero
// - Monitor off: any reset becomes power-on
// - Suspend gates clock until enabled wake
// - Power control bits 7:2 general flags
// - Power control bit one enters stop
// - Power control bit zero enters idle
`timescale 1ns/1ps
`default_nettype none
module pmw_power_wake
  import pmw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire pmw_sfr_t    sfr_req,
  output logic [7:0]       sfr_rdata_ff,
  input  wire pmw_events_t wake_events,
  input  wire logic        rst_pin_n,
  input  wire logic        irq_pending,
  input  wire logic        reset_source,
  input  wire logic        rtc_clk_buf,
  output logic             rtc_out_pin,
  output logic             rtc_out_oe,
  output logic             wake_req_pin,
  output logic             wake_req_oe,
  output logic             supply_monitor_on,
  output logic             full_por_req,
  output logic             clk_gate_en,
  output logic             lfo_disable_block,
  output pmw_mode_t        mode_ff
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [PMW_NUM_SRC-1:0] ev_meta_ff;
  logic [PMW_NUM_SRC-1:0] ev_sync_ff;
  logic [PMW_NUM_SRC-1:0] ev_prev_ff;
  logic                   rst_meta_ff;
  logic                   rst_sync_ff;
  logic                   rst_prev_ff;

  // Reset values equal the idle pin levels, so no false edge follows reset
  // Two flops before any logic reads an event or the reset pin
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ev_meta_ff  <= PMW_RST_SRC;
      ev_sync_ff  <= PMW_RST_SRC;
      ev_prev_ff  <= PMW_RST_SRC;
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= 1'b1;
      rst_prev_ff <= 1'b1;
    end else begin
      ev_meta_ff  <= wake_events;
      ev_sync_ff  <= ev_meta_ff;
      ev_prev_ff  <= ev_sync_ff;
      rst_meta_ff <= rst_pin_n;
      rst_sync_ff <= rst_meta_ff;
      rst_prev_ff <= rst_sync_ff;
    end
  end

  // Rising edges are the events; levels held high count once
  logic [PMW_NUM_SRC-1:0] ev_pulse;
  logic                   rst_fall;
  assign ev_pulse = ev_sync_ff & ~ev_prev_ff;
  assign rst_fall = rst_prev_ff & ~rst_sync_ff;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  logic wr_cfg;
  logic wr_md;
  logic wr_fl;
  logic wr_pc;
  // Power control answers on every page; the others also need the page
  always_comb begin
    wr_cfg = 1'b0;
    wr_md  = 1'b0;
    wr_fl  = 1'b0;
    wr_pc  = 1'b0;
    if (sfr_req.wr && sfr_req.addr == PMW_ADDR_POWER_CONTROL) begin
      wr_pc = 1'b1;
    end else if (sfr_req.wr && sfr_req.addr == PMW_ADDR_WAKE_CONFIG
                 && sfr_req.page == PMW_PAGE_WAKE) begin
      wr_cfg = 1'b1;
    end else if (sfr_req.wr && sfr_req.addr == PMW_ADDR_UNIT_MODE
                 && sfr_req.page == PMW_PAGE_MODE) begin
      wr_md = 1'b1;
    end else if (sfr_req.wr && sfr_req.addr == PMW_ADDR_TOUCH_FLAG
                 && sfr_req.page == PMW_PAGE_WAKE) begin
      wr_fl = 1'b1;
    end
  end

  // Clear acts only on a written one
  logic clr_all;
  assign clr_all = wr_cfg && sfr_req.wdata[PMW_CF_CLEAR];

  // ---------------------------------------------------------------------
  // Wake sources
  // ---------------------------------------------------------------------
  logic [PMW_NUM_SRC-1:0] src_en;
  logic [PMW_NUM_SRC-1:0] src_flag;
  logic [PMW_NUM_SRC-1:0] src_wr;
  logic [PMW_NUM_SRC-1:0] src_val;
  logic                   rst_flag_ff;

  // Order: fail, alarm, match, comparator from config; touch from flag reg
  // Touch enable lives in its own register and so has its own strobe
  assign src_wr  = {wr_fl, {4{wr_cfg}}};
  assign src_val = {sfr_req.wdata[PMW_FL_TOUCH],
                    sfr_req.wdata[PMW_CF_CMP],
                    sfr_req.wdata[PMW_CF_PMAT],
                    sfr_req.wdata[PMW_CF_ALARM],
                    sfr_req.wdata[PMW_CF_FAIL]};

  // One cell per source keeps enable and flag timing identical
  genvar gi;
  generate
    for (gi = 0; gi < PMW_NUM_SRC; gi++) begin : g_src
      pmw_flag_cell u_cell (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .en_wr    (src_wr[gi]),
        .en_val   (src_val[gi]),
        .clr      (clr_all),
        .event_in (ev_pulse[gi]),
        .enable_ff(src_en[gi]),
        .flag_ff  (src_flag[gi])
      );
    end
  endgenerate

  // Reset pin glitch flag, hardware set only
  // No write path: only the clear bit takes it back to zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rst_flag_ff <= 1'b0;
    end else if (rst_fall) begin
      rst_flag_ff <= 1'b1;
    end else if (clr_all) begin
      rst_flag_ff <= 1'b0;
    end
  end

  // The pin flag counts too, so a glitch also keeps the deep modes out
  logic any_flag;
  assign any_flag = rst_flag_ff || (|src_flag);
  assign lfo_disable_block = any_flag;

  // ---------------------------------------------------------------------
  // Mode and general purpose registers
  // ---------------------------------------------------------------------
  logic       rtc_oe_ff;
  logic       wake_oe_ff;
  logic       mon_dis_ff;
  logic [5:0] gp_flags_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rtc_oe_ff  <= 1'b0;
      wake_oe_ff <= 1'b0;
      mon_dis_ff <= 1'b0;
    end else if (wr_md) begin
      rtc_oe_ff  <= sfr_req.wdata[PMW_MD_RTC];
      wake_oe_ff <= sfr_req.wdata[PMW_MD_WAKE];
      mon_dis_ff <= sfr_req.wdata[PMW_MD_MON];
    end
  end

  // General flags store whatever is written
  // They carry no function here; software uses them as spare state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gp_flags_ff <= PMW_RST_GF;
    end else if (wr_pc) begin
      gp_flags_ff <= sfr_req.wdata[PMW_PC_GF_HI:PMW_PC_GF_LO];
    end
  end

  // Any reset while the monitor is off must be widened to a power-on reset
  // The monitor comes back when bit five is written zero or on reset
  assign supply_monitor_on = !mon_dis_ff;
  assign full_por_req      = mon_dis_ff && reset_source;

  // ---------------------------------------------------------------------
  // Power mode state machine
  // ---------------------------------------------------------------------
  pmw_mode_t nxt_mode;
  logic      enabled_wake;
  logic [1:0] blank_cnt_ff;
  logic       sleep_exit_ff;

  // Enabled wake uses raw pulses; the reset pin always wakes
  // Limitation: an enabled touch source ends sleep too; keep it off first
  // Sleep outranks suspend when one write sets both select bits
  assign enabled_wake = (|(ev_pulse & src_en)) || rst_fall;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      PMW_RUN: begin
        // Flags block deep modes; entry only on a written one
        // Stop and idle ignore the flags; stop ends by reset, idle by interrupt
        if (wr_cfg && sfr_req.wdata[PMW_CF_SLEEP] && !any_flag) begin
          nxt_mode = PMW_SLEEP;
        end else if (wr_cfg && sfr_req.wdata[PMW_CF_SUSPEND] && !any_flag) begin
          nxt_mode = PMW_SUSPEND;
        end else if (wr_pc && sfr_req.wdata[PMW_PC_STOP]) begin
          nxt_mode = PMW_STOP;
        end else if (wr_pc && sfr_req.wdata[PMW_PC_IDLE]) begin
          nxt_mode = PMW_IDLE;
        end
      end
      PMW_IDLE: begin
        if (irq_pending) begin
          nxt_mode = PMW_RUN;
        end
      end
      PMW_STOP: begin
        // Only a device reset leaves stop; reset_n returns to run
        nxt_mode = PMW_STOP;
      end
      PMW_SUSPEND, PMW_SLEEP: begin
        if (enabled_wake) begin
          nxt_mode = PMW_RUN;
        end
      end
      default: begin
        nxt_mode = PMW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_ff <= PMW_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Clock runs only outside suspend, sleep and stop
  assign clk_gate_en = (mode_ff == PMW_RUN) || (mode_ff == PMW_IDLE);

  // Blanking counter after leaving suspend
  // Loaded on the exit edge, so the first two run cycles read zero
  // Trade-off: raw flags still block mode entry while reads are blank
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      blank_cnt_ff <= 2'h0;
    end else if (mode_ff == PMW_SUSPEND && nxt_mode == PMW_RUN) begin
      blank_cnt_ff <= PMW_WAKE_BLANK;
    end else if (blank_cnt_ff != 2'h0) begin
      blank_cnt_ff <= blank_cnt_ff - 2'h1;
    end
  end

  // Wake request is held low from the sleep exit until rewritten or sleep is entered again
  // Holding it low gives slow neighbours time to see the request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sleep_exit_ff <= 1'b0;
    end else if (mode_ff == PMW_SLEEP && nxt_mode == PMW_RUN) begin
      sleep_exit_ff <= 1'b1;
    end else if (wr_md || nxt_mode == PMW_SLEEP) begin
      sleep_exit_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------
  assign rtc_out_oe   = rtc_oe_ff;
  assign rtc_out_pin  = rtc_oe_ff && rtc_clk_buf;
  assign wake_req_oe  = wake_oe_ff;
  assign wake_req_pin = !sleep_exit_ff;

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------
  logic [7:0] nxt_rdata;
  logic       blank;
  assign blank = (blank_cnt_ff != 2'h0);

  always_comb begin
    // Unmapped addresses and write-only bits fall through as zero
    nxt_rdata = PMW_RST_BYTE;
    if (sfr_req.addr == PMW_ADDR_POWER_CONTROL) begin
      nxt_rdata[PMW_PC_GF_HI:PMW_PC_GF_LO] = gp_flags_ff;
    end else if (sfr_req.addr == PMW_ADDR_WAKE_CONFIG
                 && sfr_req.page == PMW_PAGE_WAKE) begin
      if (!blank) begin
        nxt_rdata[PMW_CF_PIN]   = rst_flag_ff;
        nxt_rdata[PMW_CF_FAIL]  = src_flag[0];
        nxt_rdata[PMW_CF_ALARM] = src_flag[1];
        nxt_rdata[PMW_CF_PMAT]  = src_flag[2];
        nxt_rdata[PMW_CF_CMP]   = src_flag[3];
      end
    end else if (sfr_req.addr == PMW_ADDR_UNIT_MODE
                 && sfr_req.page == PMW_PAGE_MODE) begin
      nxt_rdata[PMW_MD_RTC]  = rtc_oe_ff;
      nxt_rdata[PMW_MD_WAKE] = wake_oe_ff;
      nxt_rdata[PMW_MD_MON]  = mon_dis_ff;
    end else if (sfr_req.addr == PMW_ADDR_TOUCH_FLAG
                 && sfr_req.page == PMW_PAGE_WAKE) begin
      nxt_rdata[PMW_FL_TOUCH] = blank ? 1'b0 : src_flag[4];
    end
  end

  // Flags are read live; one set during the read shows on the next read
  // Registered read: data valid the cycle after rd
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sfr_rdata_ff <= PMW_RST_BYTE;
    end else if (sfr_req.rd) begin
      sfr_rdata_ff <= nxt_rdata;
    end
  end

endmodule // pmw_power_wake
`default_nettype wire

// >>> hdl/pmw_pkg.sv
/*
  Package for the power mode and wake-up control block: register offsets,
  SFR pages, bit positions, reset values and the mode state encoding.
  Assumes an 8-bit special function register bus on the system clock.
*/
package pmw_pkg;

  // ---------------------------------------------------------------------
  // Register addresses and pages
  // ---------------------------------------------------------------------
  localparam logic [7:0] PMW_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] PMW_ADDR_WAKE_CONFIG   = 8'hB5;
  localparam logic [7:0] PMW_ADDR_UNIT_MODE     = 8'hB5;
  localparam logic [7:0] PMW_ADDR_TOUCH_FLAG    = 8'hCE;
  localparam logic [3:0] PMW_PAGE_WAKE          = 4'h0;
  localparam logic [3:0] PMW_PAGE_MODE          = 4'hF;

  // ---------------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------------
  localparam int PMW_CF_SLEEP   = 7;
  localparam int PMW_CF_SUSPEND = 6;
  localparam int PMW_CF_CLEAR   = 5;
  localparam int PMW_CF_PIN     = 4;
  localparam int PMW_CF_FAIL    = 3;
  localparam int PMW_CF_ALARM   = 2;
  localparam int PMW_CF_PMAT    = 1;
  localparam int PMW_CF_CMP     = 0;
  localparam int PMW_FL_TOUCH   = 0;
  localparam int PMW_MD_RTC     = 7;
  localparam int PMW_MD_WAKE    = 6;
  localparam int PMW_MD_MON     = 5;
  localparam int PMW_PC_STOP    = 1;
  localparam int PMW_PC_IDLE    = 0;
  localparam int PMW_PC_GF_LO   = 2;
  localparam int PMW_PC_GF_HI   = 7;

  // ---------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [7:0] PMW_RST_BYTE     = 8'h00;
  localparam logic [5:0] PMW_RST_GF       = 6'h00;
  localparam logic [4:0] PMW_RST_SRC      = 5'h00;
  localparam logic [1:0] PMW_WAKE_BLANK   = 2'h2; // System clocks flags read zero
  localparam int         PMW_NUM_SRC      = 5;    // Fail, alarm, match, cmp, touch

  // Power mode state
  typedef enum logic [2:0] {
    PMW_RUN     = 3'b000,
    PMW_IDLE    = 3'b001,
    PMW_STOP    = 3'b010,
    PMW_SUSPEND = 3'b011,
    PMW_SLEEP   = 3'b100
  } pmw_mode_t;

  // SFR bus request carried as one bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmw_sfr_t;

  // Wake event pulses, index order matches the source vector
  typedef struct packed {
    logic touch;
    logic cmp_rise;
    logic port_match;
    logic rtc_alarm;
    logic rtc_fail;
  } pmw_events_t;

endpackage

// >>> hdl/pmw_flag_cell.sv
/*
  One wake source: a write-enable bit and a sticky event flag.
  Assumes event pulses are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pmw_flag_cell
  import pmw_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic en_wr,
  input  wire logic en_val,
  input  wire logic clr,
  input  wire logic event_in,
  output logic      enable_ff,
  output logic      flag_ff
);

  // ---------------------------------------------------------------------
  // Enable bit
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      enable_ff <= 1'b0;
    end else if (en_wr) begin
      enable_ff <= en_val;
    end
  end

  // Flag: set regardless of enable, set beats clear so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
    end else if (event_in) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end

endmodule // pmw_flag_cell
`default_nettype wire

// >>> verification/pmw_power_wake_asserts.sv
/*
  Port-level checker for the power mode and wake-up block.
  Assumes it is bound to pmw_power_wake and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmw_power_wake_asserts
  import pmw_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire pmw_sfr_t    sfr_req,
  input wire logic [7:0]  sfr_rdata_ff,
  input wire logic        reset_source,
  input wire logic        rtc_clk_buf,
  input wire logic        rtc_out_pin,
  input wire logic        rtc_out_oe,
  input wire logic        wake_req_pin,
  input wire logic        supply_monitor_on,
  input wire logic        full_por_req,
  input wire logic        clk_gate_en,
  input wire logic        lfo_disable_block,
  input wire pmw_mode_t   mode_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic cfg_wr;
  logic pc_wr;
  logic run_now;
  assign cfg_wr  = sfr_req.wr && sfr_req.addr == PMW_ADDR_WAKE_CONFIG
                   && sfr_req.page == PMW_PAGE_WAKE;
  assign pc_wr   = sfr_req.wr && sfr_req.addr == PMW_ADDR_POWER_CONTROL;
  assign run_now = mode_ff == PMW_RUN;

  // Leaving sleep is two steps: asleep, then running again
  sequence s_sleep_exit;
    mode_ff == PMW_SLEEP ##1 mode_ff == PMW_RUN;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_sleep_entry: assert property (cfg_wr && sfr_req.wdata[7] && !lfo_disable_block && run_now
    |=> mode_ff == PMW_SLEEP) else $error("sleep not entered");
  a_suspend_entry: assert property (cfg_wr && sfr_req.wdata[7:6] == 2'b01 && !lfo_disable_block
    && run_now |=> mode_ff == PMW_SUSPEND) else $error("suspend not entered");
  a_flag_blocks_entry: assert property (cfg_wr && sfr_req.wdata[7:6] != 2'b00 && lfo_disable_block
    && run_now |=> run_now) else $error("entry taken with flag set");
  a_stop_entry: assert property (pc_wr && sfr_req.wdata[1:0] == 2'b10 && run_now
    |=> mode_ff == PMW_STOP) else $error("stop not entered");
  a_idle_entry: assert property (pc_wr && sfr_req.wdata[1:0] == 2'b01 && run_now
    |=> mode_ff == PMW_IDLE) else $error("idle not entered");
  a_clock_gate: assert property (clk_gate_en == (mode_ff inside {PMW_RUN, PMW_IDLE}))
    else $error("clock gate wrong for mode");
  a_wake_req_low: assert property (s_sleep_exit |-> ##[0:1] !wake_req_pin)
    else $error("wake request not low after sleep");
  a_rtc_out_route: assert property (rtc_out_pin == (rtc_out_oe && rtc_clk_buf))
    else $error("rtc output routing wrong");
  a_por_on_reset: assert property (full_por_req == (!supply_monitor_on && reset_source))
    else $error("full power-on request wrong");
  a_touch_upper_zero: assert property (sfr_req.rd && sfr_req.addr == PMW_ADDR_TOUCH_FLAG
    |=> sfr_rdata_ff[7:1] == 7'h00) else $error("touch upper bits not zero");
  a_mode_low_zero: assert property (sfr_req.rd && sfr_req.addr == PMW_ADDR_UNIT_MODE
    && sfr_req.page == PMW_PAGE_MODE |=> sfr_rdata_ff[4:0] == 5'h00)
    else $error("mode low bits not zero");
  a_cfg_wo_zero: assert property (sfr_req.rd && sfr_req.addr == PMW_ADDR_WAKE_CONFIG
    && sfr_req.page == PMW_PAGE_WAKE |=> sfr_rdata_ff[7:5] == 3'h0)
    else $error("write-only bits read nonzero");
endmodule // pmw_power_wake_asserts
`default_nettype wire

// >>> verification/pmw_core_model.sv
/*
  Core-side model: issues one-cycle register strobes on the SFR bus.
  Assumes the testbench calls its tasks hierarchically, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module pmw_core_model
  import pmw_pkg::*;
(
  input  wire logic       clk_sys,
  output pmw_sfr_t        sfr_req,
  input  wire logic [7:0] sfr_rdata_ff
);
  initial sfr_req = '0;

  // Whole-byte writes only, never read-modify-write of the config byte
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
    @(posedge clk_sys);
    sfr_req <= '0;
    #1;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [3:0] pg, input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
    @(posedge clk_sys);
    sfr_req <= '0;
    #1;
    d = sfr_rdata_ff;
  endtask
endmodule // pmw_core_model
`default_nettype wire

// >>> verification/testbench.sv
/*
  Self-checking testbench for pmw_power_wake with a core bus model.
  Assumes a free-running 20 MHz clk_sys; the clock gate is outside.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmw_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  pmw_sfr_t    sfr_req;
  logic [7:0]  sfr_rdata_ff;
  pmw_events_t wake_events = '0;
  logic        rst_pin_n = 1'b1;
  logic        irq_pending = 1'b0;
  logic        reset_source = 1'b0;
  logic        rtc_clk_buf = 1'b0;
  logic        rtc_out_pin, rtc_out_oe, wake_req_pin, wake_req_oe;
  logic        supply_monitor_on, full_por_req, clk_gate_en, lfo_disable_block;
  pmw_mode_t   mode_ff;
  logic [7:0]  rd_v;
  int          num_errors = 0;
  int          n_tests = 0;

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) rtc_clk_buf <= ~rtc_clk_buf;

  pmw_core_model u_pmw_core_model (.clk_sys(clk_sys), .sfr_req(sfr_req),
    .sfr_rdata_ff(sfr_rdata_ff));
  pmw_power_wake u_pmw_power_wake (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata_ff(sfr_rdata_ff), .wake_events(wake_events), .rst_pin_n(rst_pin_n),
    .irq_pending(irq_pending), .reset_source(reset_source), .rtc_clk_buf(rtc_clk_buf),
    .rtc_out_pin(rtc_out_pin), .rtc_out_oe(rtc_out_oe), .wake_req_pin(wake_req_pin),
    .wake_req_oe(wake_req_oe), .supply_monitor_on(supply_monitor_on),
    .full_por_req(full_por_req), .clk_gate_en(clk_gate_en),
    .lfo_disable_block(lfo_disable_block), .mode_ff(mode_ff));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    u_pmw_core_model.rd(pg, ad, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic cfg(input logic [7:0] d);
    u_pmw_core_model.wr(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, d);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  // Event held past the two-flop synchroniser and edge detector
  task automatic pulse(input int i);
    @(posedge clk_sys);
    wake_events[i] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wake_events[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_mode(input pmw_mode_t m);
    int k;
    k = 0;
    while (mode_ff !== m && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk({5'h00, mode_ff}, {5'h00, m});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({wake_req_pin, supply_monitor_on, clk_gate_en}, 8'h07);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_POWER_CONTROL, 8'h00);
    rdchk(PMW_PAGE_MODE, PMW_ADDR_UNIT_MODE, 8'h00);
    cfg(8'h20);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h00);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_TOUCH_FLAG, 8'h00);
    rdchk(PMW_PAGE_WAKE, 8'h10, 8'h00);
    $display("test reset done");
  endtask

  // Flags latch with every enable off; a set touch flag blocks sleep entry
  task automatic t_flags();
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h08 >> i);
      cfg(8'h20);
    end
    pulse(4);
    u_pmw_core_model.wr(PMW_PAGE_WAKE, PMW_ADDR_TOUCH_FLAG, 8'hFE);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_TOUCH_FLAG, 8'h01);
    cfg(8'h8F);
    chk({lfo_disable_block, mode_ff}, {1'b1, PMW_RUN});
    cfg(8'h20);
    chk({7'h00, lfo_disable_block}, 8'h00);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_TOUCH_FLAG, 8'h00);
    @(posedge clk_sys);
    rst_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h10);
    cfg(8'h20);
    $display("test flags done");
  endtask

  task automatic t_sleep();
    u_pmw_core_model.wr(PMW_PAGE_MODE, PMW_ADDR_UNIT_MODE, 8'h40);
    cfg(8'h8F);
    chk({4'h0, clk_gate_en, mode_ff}, {4'h0, 1'b0, PMW_SLEEP});
    pulse(2);
    wait_mode(PMW_RUN);
    chk({7'h00, wake_req_pin}, 8'h00);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h02);
    cfg(8'h20);
    $display("test sleep done");
  endtask

  // A source left disabled must not end suspend, but still flags
  task automatic t_suspend();
    cfg(8'h41);
    chk({5'h00, mode_ff}, {5'h00, PMW_SUSPEND});
    pulse(0);
    chk({5'h00, mode_ff}, {5'h00, PMW_SUSPEND});
    @(posedge clk_sys);
    wake_events[3] <= 1'b1;
    wait_mode(PMW_RUN);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h00);
    @(posedge clk_sys);
    wake_events[3] <= 1'b0;
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_WAKE_CONFIG, 8'h09);
    cfg(8'h20);
    $display("test suspend done");
  endtask

  task automatic t_modereg();
    u_pmw_core_model.wr(PMW_PAGE_MODE, PMW_ADDR_UNIT_MODE, 8'hFF);
    rdchk(PMW_PAGE_MODE, PMW_ADDR_UNIT_MODE, 8'hE0);
    chk({rtc_out_oe, wake_req_oe, supply_monitor_on}, 8'h06);
    chk({7'h00, rtc_out_pin}, {7'h00, rtc_clk_buf});
    @(posedge clk_sys);
    reset_source <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({7'h00, full_por_req}, 8'h01);
    @(posedge clk_sys);
    reset_source <= 1'b0;
    u_pmw_core_model.wr(PMW_PAGE_MODE, PMW_ADDR_UNIT_MODE, 8'h00);
    chk({rtc_out_oe, wake_req_oe, supply_monitor_on}, 8'h01);
    chk({7'h00, rtc_out_pin}, 8'h00);
    $display("test mode register done");
  endtask

  // Stop only ends by reset, so it runs last
  task automatic t_power_control();
    u_pmw_core_model.wr(PMW_PAGE_MODE, PMW_ADDR_POWER_CONTROL, 8'hA9);
    chk({5'h00, mode_ff}, {5'h00, PMW_IDLE});
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    wait_mode(PMW_RUN);
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_POWER_CONTROL, 8'hA8);
    u_pmw_core_model.wr(PMW_PAGE_WAKE, PMW_ADDR_POWER_CONTROL, 8'hFE);
    chk({5'h00, mode_ff}, {5'h00, PMW_STOP});
    do_reset();
    wait_mode(PMW_RUN);
    rdchk(PMW_PAGE_WAKE, PMW_ADDR_POWER_CONTROL, 8'h00);
    $display("test power control done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    t_reset();
    t_flags();
    t_sleep();
    t_suspend();
    t_modereg();
    t_power_control();
    end_sim();
  end

  // About 160 cycles expected; cut off well beyond that
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end
endmodule // testbench

bind pmw_power_wake pmw_power_wake_asserts u_pmw_power_wake_asserts (
  .clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata_ff(sfr_rdata_ff),
  .reset_source(reset_source), .rtc_clk_buf(rtc_clk_buf), .rtc_out_pin(rtc_out_pin),
  .rtc_out_oe(rtc_out_oe), .wake_req_pin(wake_req_pin),
  .supply_monitor_on(supply_monitor_on), .full_por_req(full_por_req),
  .clk_gate_en(clk_gate_en), .lfo_disable_block(lfo_disable_block), .mode_ff(mode_ff));
`default_nettype wire
